/* File: src/tdc_pkg.sv */
// How it works
// - forced-halt write completes a pending debug halt
// - forced halt holds until full device reset
// - forced-halt write ignored without pending halt
// - forced-halt bit always reads zero
// - normal halt waits for drained, accepted transactions
// - registers reached only via select/data pair
// - source bit picks process id or trace id
// - periodic-ownership-off bit suppresses periodic events
// - timestamp field: off, every message, every 32
// - event out follows selected watchpoints at 00
// - event in at 00 requests sync message
// - software write beats hardware trace-type update
// - event input always usable as watchpoint condition
// - selection bit n enables watchpoint n+1
// - halted flag set while halted; resume clears it after a normal halt, only reset after a forced one
package tdc_pkg;
  // *****************************************************
  // indirect access
  // *****************************************************
  localparam int          REG_IDX_W      = 8;
  localparam int          DATA_W         = 32;
  localparam logic        SPR_SELECT     = 1'b0;
  localparam logic        SPR_DATA       = 1'b1;
  localparam logic [7:0]  IDX_EXT_DEBUG  = 8'h00;
  localparam logic [7:0]  IDX_TRACE_CTL  = 8'h01;
  localparam logic [7:0]  IDX_EVT_SELECT = 8'h02;

  // *****************************************************
  // field positions (32-bit word, bit 0 is lsb)
  // *****************************************************
  localparam int          BIT_FORCED_HALT  = 28;
  localparam int          BIT_OWN_SRC      = 24;
  localparam int          BIT_PERIODIC_OFF = 14;
  localparam int          TS_LO            = 12;
  localparam int          EOC_LO           = 10;
  localparam int          EIC_LO           = 8;
  localparam int          TM_LO            = 0;
  localparam int          TM_W             = 6;
  localparam int          TM_RSVD_BIT      = 4;
  localparam int          WP_N             = 14;

  // *****************************************************
  // field encodings and reset values
  // *****************************************************
  localparam logic [1:0]  TS_EVERY    = 2'h2;
  localparam logic [1:0]  TS_COARSE   = 2'h3;
  localparam logic [1:0]  EOC_ACTIVE  = 2'h0;
  localparam logic [1:0]  EIC_SYNC    = 2'h0;
  localparam int          TS_CNT_W    = 5;
  localparam logic [4:0]  TS_CNT_ZERO = 5'h00;
  localparam logic [4:0]  TS_CNT_ONE  = 5'h01;
  localparam logic [5:0]  TM_RSVD_MASK = 6'h2f;

  typedef enum logic [1:0] {
    HS_RUN,
    HS_DRAIN,
    HS_HALTED,
    HS_FORCED
  } tdc_halt_state_t;

  // reserved trace-type bit never stored, whoever writes it
  function automatic logic [TM_W-1:0] tdc_tm_clean(input logic [TM_W-1:0] v);
    tdc_tm_clean = v & TM_RSVD_MASK;
  endfunction : tdc_tm_clean
endpackage : tdc_pkg

/* File: src/tdc_halt_if.sv */
`timescale 1ns/10ps
interface tdc_halt_if;
  logic haltReq;
  logic resumeReq;
  logic queueEmpty;
  logic fabricIdle;
  logic forceHalt;
  logic halted;
  logic forced;
  logic drainReq;

  modport ctl (input haltReq, resumeReq, queueEmpty, fabricIdle, forceHalt,
               output halted, forced, drainReq);
  modport top (output haltReq, resumeReq, queueEmpty, fabricIdle, forceHalt,
               input halted, forced, drainReq);
endinterface : tdc_halt_if

/* File: src/tdc_halt_ctl.sv */
`timescale 1ns/10ps
module tdc_halt_ctl
  import tdc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // halt handshake
  tdc_halt_if.ctl   hb
);
  typedef struct packed {
    tdc_halt_state_t st;
  } tdc_halt_reg_t;

  tdc_halt_reg_t cur_ff, nxt_cur;

  always_comb
  begin
    nxt_cur = cur_ff;
    case (cur_ff.st)
      HS_RUN:
        if (hb.haltReq)
          nxt_cur.st = HS_DRAIN;
      HS_DRAIN:
        if (hb.forceHalt)
          nxt_cur.st = HS_FORCED;
        else if (hb.queueEmpty && hb.fabricIdle)
          nxt_cur.st = HS_HALTED;
      HS_HALTED:
        if (hb.resumeReq)
          nxt_cur.st = HS_RUN;
      HS_FORCED:
        nxt_cur.st = HS_FORCED;
      default:
        nxt_cur.st = HS_RUN;
    endcase
    if (rst)
      nxt_cur.st = HS_RUN;
  end

  always_ff @(posedge clk)
  begin
    cur_ff <= nxt_cur;
  end

  assign hb.halted   = (cur_ff.st == HS_HALTED) || (cur_ff.st == HS_FORCED);
  assign hb.forced   = (cur_ff.st == HS_FORCED);
  assign hb.drainReq = (cur_ff.st == HS_DRAIN);

  // *****************************************************
  // checks
  // *****************************************************
  property p_force_halts;
    @(posedge clk) disable iff (rst)
      (cur_ff.st == HS_DRAIN && hb.forceHalt) |=> (cur_ff.st == HS_FORCED);
  endproperty
  a_force_halts: assert property (p_force_halts)
    else $error("forced halt did not complete");

  property p_forced_sticky;
    @(posedge clk) disable iff (rst)
      // a one-edge reset pulse must not count as leaving the forced state
      (!rst && cur_ff.st == HS_FORCED) |=> (cur_ff.st == HS_FORCED) [*2];
  endproperty
  a_forced_sticky: assert property (p_forced_sticky)
    else $error("forced halt left without reset");

  property p_force_ignored;
    @(posedge clk) disable iff (rst)
      (cur_ff.st != HS_DRAIN && hb.forceHalt) |=> (cur_ff.st != HS_FORCED || $past(hb.forced));
  endproperty
  a_force_ignored: assert property (p_force_ignored)
    else $error("forced halt taken with no pending halt");

  property p_drain_first;
    @(posedge clk) disable iff (rst)
      $rose(cur_ff.st == HS_HALTED) |-> $past(hb.queueEmpty && hb.fabricIdle);
  endproperty
  a_drain_first: assert property (p_drain_first)
    else $error("halted before transactions were accepted");
endmodule : tdc_halt_ctl

/* File: src/tdc_trace_ctl.sv */
`timescale 1ns/10ps
module tdc_trace_ctl
  import tdc_pkg::*;
#(
  parameter int WP_COUNT = WP_N
)
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // indirect access pair
  input  wire logic                 sprWrEn,
  input  wire logic                 sprRdEn,
  input  wire logic                 sprSel,
  input  wire logic [DATA_W-1:0]    sprWdata,
  output logic      [DATA_W-1:0]    sprRdata,
  // core halt handshake
  input  wire logic                 haltReq,
  input  wire logic                 resumeReq,
  input  wire logic                 queueEmpty,
  input  wire logic                 fabricIdle,
  output logic                      halted,
  output logic                      forcedHalted,
  output logic                      drainReq,
  // trace sources and events
  input  wire logic [DATA_W-1:0]    processIdZero,
  input  wire logic [DATA_W-1:0]    traceProcessId,
  input  wire logic                 msgStrobe,
  input  wire logic [WP_COUNT-1:0]  wpHit,
  input  wire logic                 eventInputZero,
  input  wire logic                 hwTmWr,
  input  wire logic [TM_W-1:0]      hwTmVal,
  // trace controls out
  output logic      [DATA_W-1:0]    ownershipId,
  output logic                      periodicOwnEn,
  output logic                      tsApply,
  output logic      [TM_W-1:0]      traceTypeEn,
  output logic                      eventOutputZero,
  output logic                      syncReq,
  output logic                      eventInWatch
);
  typedef struct packed {
    logic [REG_IDX_W-1:0] sel;
    logic                 ownSrc;
    logic                 periodicOff;
    logic [1:0]           tsSet;
    logic [1:0]           eoc;
    logic [1:0]           event_in_control;
    logic [TM_W-1:0]      tm;
    logic [WP_COUNT-1:0]  wpSel;
    logic [DATA_W-1:0]    rdata;
    logic                 evtSync1;
    logic                 evtSync2;
    logic                 evtPrev;
    logic                 evtOut;
    logic                 sync;
    logic                 evtWatch;
    logic                 ts;
    logic [TS_CNT_W-1:0]  tsCnt;
    logic [DATA_W-1:0]    ownId;
    logic                 haltedQ;
    logic                 forcedQ;
    logic                 drainQ;
  } tdc_trace_reg_t;

  tdc_trace_reg_t cur_ff, nxt_cur;
  logic           dataWr;
  logic           dataRd;
  tdc_halt_if     hb ();

  assign dataWr = sprWrEn && sprSel == SPR_DATA;
  assign dataRd = sprRdEn && sprSel == SPR_DATA;

  // *****************************************************
  // halt control
  // *****************************************************
  assign hb.haltReq    = haltReq;
  assign hb.resumeReq  = resumeReq;
  assign hb.queueEmpty = queueEmpty;
  assign hb.fabricIdle = fabricIdle;
  // only a data write to the extended control word with the bit set
  assign hb.forceHalt  = dataWr && cur_ff.sel == IDX_EXT_DEBUG
                         && sprWdata[BIT_FORCED_HALT];

  tdc_halt_ctl u_halt (
    .clk (clk),
    .rst (rst),
    .hb  (hb.ctl)
  );

  // *****************************************************
  // registers and trace controls
  // *****************************************************
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.evtSync1 = eventInputZero;
    nxt_cur.evtSync2 = cur_ff.evtSync1;
    nxt_cur.evtPrev  = cur_ff.evtSync2;
    nxt_cur.haltedQ  = hb.halted;
    nxt_cur.forcedQ  = hb.forced;
    nxt_cur.drainQ   = hb.drainReq;

    // hardware update first so a software write overrides it
    if (hwTmWr)
      nxt_cur.tm = tdc_tm_clean(hwTmVal);
    if (sprWrEn && sprSel == SPR_SELECT)
      nxt_cur.sel = sprWdata[REG_IDX_W-1:0];
    if (dataWr && cur_ff.sel == IDX_TRACE_CTL)
    begin
      nxt_cur.ownSrc      = sprWdata[BIT_OWN_SRC];
      nxt_cur.periodicOff = sprWdata[BIT_PERIODIC_OFF];
      nxt_cur.tsSet       = sprWdata[TS_LO +: 2];
      nxt_cur.eoc         = sprWdata[EOC_LO +: 2];
      nxt_cur.event_in_control         = sprWdata[EIC_LO +: 2];
      nxt_cur.tm          = tdc_tm_clean(sprWdata[TM_LO +: TM_W]);
    end
    if (dataWr && cur_ff.sel == IDX_EVT_SELECT)
      nxt_cur.wpSel = sprWdata[WP_COUNT-1:0];

    if (sprSel == SPR_SELECT && sprRdEn)
    begin
      nxt_cur.rdata = '0;
      nxt_cur.rdata[REG_IDX_W-1:0] = cur_ff.sel;
    end
    else if (dataRd)
    begin
      nxt_cur.rdata = '0;
      case (cur_ff.sel)
        IDX_TRACE_CTL:
        begin
          nxt_cur.rdata[BIT_OWN_SRC]       = cur_ff.ownSrc;
          nxt_cur.rdata[BIT_PERIODIC_OFF]  = cur_ff.periodicOff;
          nxt_cur.rdata[TS_LO +: 2]        = cur_ff.tsSet;
          nxt_cur.rdata[EOC_LO +: 2]       = cur_ff.eoc;
          nxt_cur.rdata[EIC_LO +: 2]       = cur_ff.event_in_control;
          nxt_cur.rdata[TM_LO +: TM_W]     = cur_ff.tm;
        end
        IDX_EVT_SELECT:
          nxt_cur.rdata[WP_COUNT-1:0] = cur_ff.wpSel;
        default:
          nxt_cur.rdata = '0;
      endcase
    end

    nxt_cur.ownId = cur_ff.ownSrc ? traceProcessId : processIdZero;
    // bit n of the selection stands for watchpoint n+1
    nxt_cur.evtOut = (cur_ff.eoc == EOC_ACTIVE) && |(wpHit & cur_ff.wpSel);
    nxt_cur.sync = (cur_ff.event_in_control == EIC_SYNC)
                   && cur_ff.evtSync2 && !cur_ff.evtPrev;
    nxt_cur.evtWatch = cur_ff.evtSync2;

    // coarse mode marks the first of each block of 32 messages
    nxt_cur.ts = 1'b0;
    if (msgStrobe)
    begin
      if (cur_ff.tsSet == TS_EVERY)
        nxt_cur.ts = 1'b1;
      else if (cur_ff.tsSet == TS_COARSE)
        nxt_cur.ts = (cur_ff.tsCnt == TS_CNT_ZERO);
      nxt_cur.tsCnt = cur_ff.tsCnt + TS_CNT_ONE;
    end
    if (!cur_ff.tsSet[1])
      nxt_cur.tsCnt = TS_CNT_ZERO;

    if (rst)
      nxt_cur = '0;
  end

  always_ff @(posedge clk)
  begin
    cur_ff <= nxt_cur;
  end

  assign sprRdata        = cur_ff.rdata;
  assign halted          = cur_ff.haltedQ;
  assign forcedHalted    = cur_ff.forcedQ;
  assign drainReq        = cur_ff.drainQ;
  assign ownershipId     = cur_ff.ownId;
  assign periodicOwnEn   = !cur_ff.periodicOff;
  assign tsApply         = cur_ff.ts;
  assign traceTypeEn     = cur_ff.tm;
  assign eventOutputZero = cur_ff.evtOut;
  assign syncReq         = cur_ff.sync;
  assign eventInWatch    = cur_ff.evtWatch;

  // *****************************************************
  // checks
  // *****************************************************
  property p_forced_reads_zero;
    @(posedge clk) disable iff (rst)
      $past(dataRd) |-> !sprRdata[BIT_FORCED_HALT];
  endproperty
  a_forced_reads_zero: assert property (p_forced_reads_zero)
    else $error("forced-halt bit read back as one");

  property p_own_src;
    @(posedge clk) disable iff (rst)
      cur_ff.ownSrc && $stable(cur_ff.ownSrc) |=> ownershipId == $past(traceProcessId);
  endproperty
  a_own_src: assert property (p_own_src)
    else $error("ownership id from wrong source");

  property p_ts_off;
    @(posedge clk) disable iff (rst)
      !cur_ff.tsSet[1] |=> !tsApply;
  endproperty
  a_ts_off: assert property (p_ts_off)
    else $error("timestamp applied while disabled");

  property p_evt_out;
    @(posedge clk) disable iff (rst)
      (cur_ff.eoc == EOC_ACTIVE && |(wpHit & cur_ff.wpSel)) |=> eventOutputZero;
  endproperty
  a_evt_out: assert property (p_evt_out)
    else $error("event output missed a selected watchpoint");

  property p_evt_out_off;
    @(posedge clk) disable iff (rst)
      cur_ff.eoc != EOC_ACTIVE |=> !eventOutputZero;
  endproperty
  a_evt_out_off: assert property (p_evt_out_off)
    else $error("event output active while disabled");

  property p_tm_rsvd;
    @(posedge clk) disable iff (rst)
      1'b1 |-> !traceTypeEn[TM_RSVD_BIT];
  endproperty
  a_tm_rsvd: assert property (p_tm_rsvd)
    else $error("reserved trace-type bit set");

  property p_sw_wins;
    @(posedge clk) disable iff (rst)
      (hwTmWr && dataWr && cur_ff.sel == IDX_TRACE_CTL)
      |=> traceTypeEn == tdc_tm_clean($past(sprWdata[TM_LO +: TM_W]));
  endproperty
  a_sw_wins: assert property (p_sw_wins)
    else $error("hardware update beat software write");

  property p_halted_flag;
    @(posedge clk) disable iff (rst)
      // the flag copy is cleared by reset, so the edge that samples rst is skipped
      !rst && hb.halted |=> halted;
  endproperty
  a_halted_flag: assert property (p_halted_flag)
    else $error("halted flag not shown");
endmodule : tdc_trace_ctl

/* File: testbench/tdc_dbg_model.sv */
`timescale 1ns/10ps
module tdc_dbg_model
  import tdc_pkg::*;
(
  // clock
  input  wire logic              clk,
  // indirect access pair
  output logic                   sprWrEn,
  output logic                   sprRdEn,
  output logic                   sprSel,
  output logic      [DATA_W-1:0] sprWdata,
  input  wire logic [DATA_W-1:0] sprRdata
);
  initial
  begin
    sprWrEn  = 1'b0;
    sprRdEn  = 1'b0;
    sprSel   = SPR_SELECT;
    sprWdata = '0;
  end

  // every access goes through the select/data pair
  // forcing is requested by tests both with no halt pending and once a halt is stuck
  // the model has no command that reaches the fabric
  task automatic wr(input logic [7:0] idx, input logic [DATA_W-1:0] d);
    @(posedge clk);
    sprWrEn  <= 1'b1;
    sprSel   <= SPR_SELECT;
    sprWdata <= {24'h000000, idx};
    @(posedge clk);
    sprSel   <= SPR_DATA;
    sprWdata <= d;
    @(posedge clk);
    sprWrEn  <= 1'b0;
    // released data must not look like a held value
    sprWdata <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [DATA_W-1:0] d);
    @(posedge clk);
    sprWrEn  <= 1'b1;
    sprSel   <= SPR_SELECT;
    sprWdata <= {24'h000000, idx};
    @(posedge clk);
    sprWrEn  <= 1'b0;
    sprWdata <= ~{24'h000000, idx};
    sprRdEn  <= 1'b1;
    sprSel   <= SPR_DATA;
    @(posedge clk);
    sprRdEn  <= 1'b0;
    @(posedge clk);
    #1;
    d = sprRdata;
  endtask : rd
endmodule : tdc_dbg_model

/* File: testbench/testbench.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module testbench
  import tdc_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, sprWrEn, sprRdEn, sprSel, haltReq = 1'b0, resumeReq = 1'b0;
  logic queueEmpty = 1'b0, fabricIdle = 1'b0, msgStrobe = 1'b0, eventInputZero = 1'b0;
  logic hwTmWr = 1'b0, halted, forcedHalted, drainReq, periodicOwnEn, tsApply;
  logic eventOutputZero, syncReq, eventInWatch;
  logic [DATA_W-1:0] sprWdata, sprRdata, ownershipId, rdv, v;
  logic [DATA_W-1:0] processIdZero = '0, traceProcessId = '0;
  logic [WP_N-1:0]   wpHit = '0, wsel, hit;
  logic [TM_W-1:0]   hwTmVal = '0, traceTypeEn;
  logic [1:0]        tsOrder [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  int n_fail = 0, samples_checked = 0, cycles = 0, tsCnt = 0, syncCnt = 0, base, seedDummy;

  always #50 clk = ~clk;

  tdc_dbg_model p (.clk(clk), .sprWrEn(sprWrEn), .sprRdEn(sprRdEn), .sprSel(sprSel),
                   .sprWdata(sprWdata), .sprRdata(sprRdata));

  tdc_trace_ctl DUT (.clk(clk), .rst(rst), .sprWrEn(sprWrEn), .sprRdEn(sprRdEn),
    .sprSel(sprSel), .sprWdata(sprWdata), .sprRdata(sprRdata), .haltReq(haltReq),
    .resumeReq(resumeReq), .queueEmpty(queueEmpty), .fabricIdle(fabricIdle),
    .halted(halted), .forcedHalted(forcedHalted), .drainReq(drainReq),
    .processIdZero(processIdZero), .traceProcessId(traceProcessId), .msgStrobe(msgStrobe),
    .wpHit(wpHit), .eventInputZero(eventInputZero), .hwTmWr(hwTmWr), .hwTmVal(hwTmVal),
    .ownershipId(ownershipId), .periodicOwnEn(periodicOwnEn), .tsApply(tsApply),
    .traceTypeEn(traceTypeEn), .eventOutputZero(eventOutputZero), .syncReq(syncReq),
    .eventInWatch(eventInWatch));

  // ****************************************
  // expectations
  // ****************************************
  function automatic logic [31:0] expTrace(input logic [31:0] w);
    expTrace = w & 32'h01007f2f;
  endfunction : expTrace

  function automatic int expTs(input logic [1:0] ts, input int n);
    expTs = !ts[1] ? 0 : (ts == TS_EVERY) ? n : (n + 31) / 32;
  endfunction : expTs

  // ****************************************
  // helpers
  // ****************************************
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic resume();
    @(posedge clk) resumeReq <= 1'b1;
    @(posedge clk) resumeReq <= 1'b0;
  endtask : resume

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  always @(posedge clk)
  begin
    cycles++;
    if (tsApply === 1'b1) tsCnt++;
    if (syncReq === 1'b1) syncCnt++;
    if (cycles == 20000)
    begin
      n_fail++;
      conclude();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    seedDummy = $urandom(32'he05bdc9e);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    `CHK("periodicOwnEn", 1'b1, periodicOwnEn)
    p.rd(IDX_TRACE_CTL, rdv); `CHK("trace ctl reset", 32'h0, rdv)
    p.wr(8'h05, 32'hffffffff); p.rd(8'h05, rdv); `CHK("unmapped", 32'h0, rdv)
    p.wr(IDX_TRACE_CTL, 32'hffffffff); p.rd(IDX_TRACE_CTL, rdv);
    `CHK("reserved bits", expTrace(32'hffffffff), rdv)
    for (int i = 0; i < 8; i++)
    begin
      v = $urandom();
      p.wr(IDX_TRACE_CTL, v);
      @(posedge clk) processIdZero <= $urandom();
      traceProcessId <= $urandom();
      p.rd(IDX_TRACE_CTL, rdv); `CHK("trace ctl", expTrace(v), rdv)
      `CHK("types", v[TM_W-1:0] & TM_RSVD_MASK, traceTypeEn)
      `CHK("periodic", ~v[BIT_PERIODIC_OFF], periodicOwnEn)
      `CHK("own id", v[BIT_OWN_SRC] ? traceProcessId : processIdZero, ownershipId)
    end
    for (int e = 0; e < 4; e++)
    begin
      wsel = WP_N'($urandom()) | 14'h0001;
      p.wr(IDX_TRACE_CTL, 32'(e) << EOC_LO);
      p.wr(IDX_EVT_SELECT, {18'h0, wsel});
      for (int j = 0; j < 2; j++)
      begin
        hit = j ? (wsel & (~wsel + 14'h0001)) : ~wsel;
        @(posedge clk) wpHit <= hit;
        @(posedge clk) wpHit <= '0;
        #1;
        `CHK("event out", (e == 0) && j == 1, eventOutputZero)
      end
    end
    for (int t = 0; t < 4; t++)
    begin
      p.wr(IDX_TRACE_CTL, 32'(tsOrder[t]) << TS_LO);
      settle(2);
      base = tsCnt;
      repeat (33)
      begin
        @(posedge clk) msgStrobe <= 1'b1;
        @(posedge clk) msgStrobe <= 1'b0;
      end
      settle(3);
      `CHK("timestamps", expTs(tsOrder[t], 33), tsCnt - base)
    end
    for (int e = 0; e < 4; e += 2)
    begin
      p.wr(IDX_TRACE_CTL, 32'(e) << EIC_LO);
      base = syncCnt;
      @(posedge clk) eventInputZero <= 1'b1;
      settle(6);
      `CHK("sync", int'(e == 0), syncCnt - base)
      `CHK("evt watch", 1'b1, eventInWatch)
      @(posedge clk) eventInputZero <= 1'b0;
      settle(4);
    end
    @(posedge clk) hwTmWr <= 1'b1;
    hwTmVal <= 6'h3f;
    @(posedge clk) hwTmWr <= 1'b0;
    settle(2);
    `CHK("hw types", 6'h2f, traceTypeEn)
    fork
      p.wr(IDX_TRACE_CTL, 32'h00000005);
      begin
        repeat (2) @(posedge clk);
        hwTmWr <= 1'b1;
        @(posedge clk) hwTmWr <= 1'b0;
      end
    join
    settle(2);
    `CHK("collision", 6'h05, traceTypeEn)
    p.wr(IDX_EXT_DEBUG, 32'h1 << BIT_FORCED_HALT);
    settle(6);
    `CHK("idle force", 1'b0, halted)
    @(posedge clk) haltReq <= 1'b1;
    settle(4);
    `CHK("drain", 1'b1, drainReq)
    @(posedge clk) queueEmpty <= 1'b1;
    settle(8);
    `CHK("not idle", 1'b0, halted)
    @(posedge clk) fabricIdle <= 1'b1;
    settle(4);
    `CHK("halted", 1'b1, halted)
    @(posedge clk) haltReq <= 1'b0;
    resume();
    settle(4);
    `CHK("resumed", 1'b0, halted)
    @(posedge clk) queueEmpty <= 1'b0;
    fabricIdle <= 1'b0;
    haltReq <= 1'b1;
    settle(4);
    p.wr(IDX_EXT_DEBUG, 32'h1 << BIT_FORCED_HALT);
    settle(4);
    `CHK("forced", 2'b11, {halted, forcedHalted})
    p.rd(IDX_EXT_DEBUG, rdv); `CHK("force read", 32'h0, rdv)
    @(posedge clk) haltReq <= 1'b0;
    resume();
    settle(6);
    `CHK("stays forced", 1'b1, halted)
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    settle(2);
    `CHK("reset release", 2'b00, {halted, forcedHalted})
    p.rd(IDX_TRACE_CTL, rdv); `CHK("trace ctl reset", 32'h0, rdv)
    conclude();
  end
endmodule : testbench
